// ### design/t1pfd_deadtime.sv
// Purpose: dead-time generator for one complementary output pair
// Assumes: timer_tick_in is the timer clock as a one-cycle pulse
// Notes:   the falling output drops at once; only rising edges are delayed
`timescale 1ns/1ps
module t1pfd_deadtime (
   // clock and reset
   input  wire logic       mclk_in,
   input  wire logic       rst_in,
   // timing
   input  wire logic       timer_tick_in,
   input  wire logic [1:0] dead_prescale_in,
   input  wire logic [3:0] dead_time_true_output_in,
   input  wire logic [3:0] dead_time_inverted_output_in,
   // waveform
   input  wire logic       pwm_in,
   output logic            pair_true_out,
   output logic            pair_inv_out
);
   logic [2:0] pre;
   logic [2:0] pre_mask;
   logic       dt_tick;
   logic       level;
   logic [3:0] delay;
   logic       changed;

   assign pre_mask = t1pfd_pkg::t1pfd_dt_mask(dead_prescale_in);
   assign dt_tick  = timer_tick_in && ((pre & pre_mask) == pre_mask);
   assign changed  = pwm_in != level;

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         pre <= 3'h0;
      end else if (timer_tick_in) begin
         pre <= pre + 3'h1;
      end
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         level         <= 1'b0;
         delay         <= 4'h0;
         pair_true_out <= 1'b0;
         pair_inv_out  <= 1'b0;
      end else if (changed) begin
         // both low while the rising side waits out its dead time
         level         <= pwm_in;
         delay         <= pwm_in ? dead_time_true_output_in : dead_time_inverted_output_in;
         pair_true_out <= 1'b0;
         pair_inv_out  <= 1'b0;
      end else if (delay != 4'h0) begin
         if (dt_tick) begin
            delay <= delay - 4'h1;
         end
      end else begin
         pair_true_out <= level;
         pair_inv_out  <= !level;
      end
   end

   property p_no_overlap;
      @(posedge mclk_in) disable iff (rst_in) !(pair_true_out && pair_inv_out);
   endproperty
   a_no_overlap: assert property (p_no_overlap) else $error("both outputs high");

   property p_zero_delay;
      @(posedge mclk_in) disable iff (rst_in)
         (changed && pwm_in && dead_time_true_output_in == 4'h0) ##1 pwm_in |=> pair_true_out;
   endproperty
   a_zero_delay: assert property (p_zero_delay) else $error("zero dead time not immediate");

   property p_undivided;
      @(posedge mclk_in) disable iff (rst_in) (dead_prescale_in == 2'h0) |-> (dt_tick == timer_tick_in);
   endproperty
   a_undivided: assert property (p_undivided) else $error("dead-time prescale 1x wrong");

   property p_delay_hold;
      @(posedge mclk_in) disable iff (rst_in)
         (!changed && delay != 4'h0 && !dt_tick) |=> (delay == $past(delay) || changed);
   endproperty
   a_delay_hold: assert property (p_delay_hold) else $error("dead time counted without tick");
endmodule

// ### design/t1pfd_pkg.sv
// Purpose: shared constants for the timer1 prescale, flags and dead-time block
// Assumes: 32-bit APB, registers in the low bits of aligned words
// Notes:   flag and mask registers share one bit layout
package t1pfd_pkg;
   // register byte addresses
   localparam logic [7:0] ADDR_CTRL     = 8'h00;
   localparam logic [7:0] ADDR_FLAGS    = 8'h04;
   localparam logic [7:0] ADDR_MASK     = 8'h08;
   localparam logic [7:0] ADDR_COUNT    = 8'h0C;
   localparam logic [7:0] ADDR_CMP_A    = 8'h10;
   localparam logic [7:0] ADDR_CMP_B    = 8'h14;
   localparam logic [7:0] ADDR_TOP      = 8'h18;
   localparam logic [7:0] ADDR_DT_PRE   = 8'h1C;
   localparam logic [7:0] ADDR_DT_VALUE = 8'h24;
   // control register fields
   localparam int CTRL_CS_LSB    = 0;
   localparam int CTRL_ASYNC_BIT = 4;
   localparam int CTRL_MODE_LSB  = 5;
   // flag / mask layout
   localparam int FLAG_CMP_A = 6;
   localparam int FLAG_CMP_B = 5;
   localparam int FLAG_OVF   = 2;
   localparam logic [7:0] FLAG_BITS = 8'h64;
   // dead-time nibbles
   localparam int DT_TRUE_LSB = 4;
   localparam int DT_INV_LSB  = 0;
   // values after reset, counter limits and divider width
   localparam logic [7:0] RST_CTRL     = 8'h00;
   localparam logic [7:0] RST_TOP      = 8'hFF;
   localparam logic [7:0] RST_CMP      = 8'h00;
   localparam logic [7:0] RST_DT_VALUE = 8'h00;
   localparam logic [1:0] RST_DT_PRE   = 2'h0;
   localparam logic [7:0] CNT_MAX      = 8'hFF;
   localparam logic [7:0] CNT_BOTTOM   = 8'h00;
   localparam int PRESCALE_W = 14;

   typedef enum logic [1:0] {
      T1PFD_NORMAL   = 2'b00,
      T1PFD_FAST_PWM = 2'b01,
      T1PFD_PFC_PWM  = 2'b10,
      T1PFD_RSVD     = 2'b11
   } t1pfd_mode_t;

   // low mask of a power-of-two divider: code n divides by 2**(n-1)
   function automatic logic [PRESCALE_W-1:0] t1pfd_div_mask(input logic [3:0] cs);
      logic [PRESCALE_W-1:0] m;
      m = '0;
      for (int i = 0; i < PRESCALE_W; i++) begin
         if (i + 1 < int'(cs)) begin
            m[i] = 1'b1;
         end
      end
      return m;
   endfunction

   // dead-time divider mask: codes 0..3 divide by 1, 2, 4, 8
   function automatic logic [2:0] t1pfd_dt_mask(input logic [1:0] ps);
      logic [2:0] m;
      m = 3'h0;
      for (int i = 0; i < 3; i++) begin
         if (i < int'(ps)) begin
            m[i] = 1'b1;
         end
      end
      return m;
   endfunction
endpackage

// ### design/t1pfd_prescaler.sv
// Purpose: clock select prescaler, one timer tick per selected source period
// Assumes: src_tick_in is a one-cycle pulse per source clock period
// Notes:   code zero stops the timer and holds the divider at zero
`timescale 1ns/1ps
module t1pfd_prescaler (
   // clock and reset
   input  wire logic       mclk_in,
   input  wire logic       rst_in,
   // control
   input  wire logic       src_tick_in,
   input  wire logic [3:0] clk_sel_in,
   // result
   output logic            timer_tick_out
);
   logic [t1pfd_pkg::PRESCALE_W-1:0] div;
   logic [t1pfd_pkg::PRESCALE_W-1:0] div_mask;

   assign div_mask = t1pfd_pkg::t1pfd_div_mask(clk_sel_in);
   assign timer_tick_out = src_tick_in && (clk_sel_in != 4'h0) && ((div & div_mask) == div_mask);

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         div <= '0;
      end else if (clk_sel_in == 4'h0) begin
         div <= '0;
      end else if (src_tick_in) begin
         div <= div + 1'b1;
      end
   end

   property p_stop_no_tick;
      @(posedge mclk_in) disable iff (rst_in) (clk_sel_in == 4'h0) |-> !timer_tick_out;
   endproperty
   a_stop_no_tick: assert property (p_stop_no_tick) else $error("timer ticked while stopped");
endmodule

// ### design/t1pfd_top.sv
// Purpose: timer1 counter with clock select, compare and overflow flags, dead time
// Assumes: APB slave, zero wait states; fast peripheral clock arrives as a pin
// Notes:   flag clears by written one land one cycle after the write
`timescale 1ns/1ps
module t1pfd_top (
   // clock and reset
   input  wire logic        mclk_in,
   input  wire logic        rst_in,
   // apb slave
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic [31:0]      prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   // core side
   input  wire logic        global_irq_enable_in,
   input  wire logic        ack_compare_a_in,
   input  wire logic        ack_compare_b_in,
   input  wire logic        ack_overflow_in,
   output logic             compare_a_irq_out,
   output logic             compare_b_irq_out,
   output logic             overflow_irq_out,
   output logic             irq_out,
   // pins
   input  wire logic        fast_periph_clk_in,
   output logic             compare_output_pair_true_out,
   output logic             compare_output_pair_inv_out
);
   // registers
   logic [7:0]  ctrl;
   logic [7:0]  flags;
   logic [7:0]  mask;
   logic [7:0]  compare_a_value;
   logic [7:0]  compare_b_value;
   logic [7:0]  top_value;
   logic [1:0]  dead_prescale;
   logic [7:0]  dead_time_value;
   logic [7:0]  clr_pend;
   // counter
   logic [7:0]  count;
   logic        count_down;
   // fast clock sampling
   logic        fpc_s1;
   logic        fpc_s2;
   logic        fpc_s3;
   logic        fast_tick;
   logic        src_tick;
   logic        timer_tick;
   // decode and events
   logic        apb_wr;
   logic        apb_setup;
   logic        mapped;
   logic [3:0]  clk_sel;
   t1pfd_pkg::t1pfd_mode_t mode;
   logic [7:0]  top_eff;
   logic        hit_a;
   logic        hit_b;
   logic        ovf_event;
   logic [7:0]  set_vec;
   logic [7:0]  ack_vec;
   logic [7:0]  next_flags;
   logic [7:0]  next_count;
   logic        next_down;
   logic [31:0] next_rdata;
   logic        pwm_raw;

   assign clk_sel = ctrl[t1pfd_pkg::CTRL_CS_LSB +: 4];
   assign mode    = t1pfd_pkg::t1pfd_mode_t'(ctrl[t1pfd_pkg::CTRL_MODE_LSB +: 2]);
   assign top_eff = (mode == t1pfd_pkg::T1PFD_NORMAL) ? t1pfd_pkg::CNT_MAX : top_value;

   // fast peripheral clock is foreign: two flops, then edge detect
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         fpc_s1 <= 1'b0;
         fpc_s2 <= 1'b0;
         fpc_s3 <= 1'b0;
      end else begin
         fpc_s1 <= fast_periph_clk_in;
         fpc_s2 <= fpc_s1;
         fpc_s3 <= fpc_s2;
      end
   end
   assign fast_tick = fpc_s2 && !fpc_s3;
   // synchronous mode runs from the system clock itself
   assign src_tick  = ctrl[t1pfd_pkg::CTRL_ASYNC_BIT] ? fast_tick : 1'b1;

   t1pfd_prescaler i_t1pfd_prescaler (
      .mclk_in        (mclk_in),
      .rst_in         (rst_in),
      .src_tick_in    (src_tick),
      .clk_sel_in     (clk_sel),
      .timer_tick_out (timer_tick)
   );

   // apb decode
   assign apb_setup = psel_in && !penable_in;
   assign apb_wr    = psel_in && penable_in && pwrite_in;
   always_comb begin
      case (paddr_in)
         t1pfd_pkg::ADDR_CTRL,
         t1pfd_pkg::ADDR_FLAGS,
         t1pfd_pkg::ADDR_MASK,
         t1pfd_pkg::ADDR_COUNT,
         t1pfd_pkg::ADDR_CMP_A,
         t1pfd_pkg::ADDR_CMP_B,
         t1pfd_pkg::ADDR_TOP,
         t1pfd_pkg::ADDR_DT_PRE,
         t1pfd_pkg::ADDR_DT_VALUE: mapped = 1'b1;
         default:                  mapped = 1'b0;
      endcase
   end
   assign pready_out  = 1'b1;
   assign pslverr_out = psel_in && penable_in && !mapped;

   always_comb begin
      next_rdata = 32'h0000_0000;
      case (paddr_in)
         t1pfd_pkg::ADDR_CTRL:     next_rdata[7:0] = ctrl;
         t1pfd_pkg::ADDR_FLAGS:    next_rdata[7:0] = flags;
         t1pfd_pkg::ADDR_MASK:     next_rdata[7:0] = mask;
         t1pfd_pkg::ADDR_COUNT:    next_rdata[7:0] = count;
         t1pfd_pkg::ADDR_CMP_A:    next_rdata[7:0] = compare_a_value;
         t1pfd_pkg::ADDR_CMP_B:    next_rdata[7:0] = compare_b_value;
         t1pfd_pkg::ADDR_TOP:      next_rdata[7:0] = top_value;
         t1pfd_pkg::ADDR_DT_PRE:   next_rdata[1:0] = dead_prescale;
         t1pfd_pkg::ADDR_DT_VALUE: next_rdata[7:0] = dead_time_value;
         default:                  next_rdata = 32'h0000_0000;
      endcase
   end

   // read data captured in the setup cycle, shown in the access cycle
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         prdata_out <= 32'h0000_0000;
      end else if (apb_setup && !pwrite_in) begin
         prdata_out <= next_rdata;
      end
   end

   // configuration registers
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         ctrl            <= t1pfd_pkg::RST_CTRL;
         mask            <= 8'h00;
         compare_a_value <= t1pfd_pkg::RST_CMP;
         compare_b_value <= t1pfd_pkg::RST_CMP;
         top_value       <= t1pfd_pkg::RST_TOP;
         dead_prescale   <= t1pfd_pkg::RST_DT_PRE;
         dead_time_value <= t1pfd_pkg::RST_DT_VALUE;
      end else if (apb_wr) begin
         case (paddr_in)
            t1pfd_pkg::ADDR_CTRL:     ctrl            <= pwdata_in[7:0];
            t1pfd_pkg::ADDR_MASK:     mask            <= pwdata_in[7:0] & t1pfd_pkg::FLAG_BITS;
            t1pfd_pkg::ADDR_CMP_A:    compare_a_value <= pwdata_in[7:0];
            t1pfd_pkg::ADDR_CMP_B:    compare_b_value <= pwdata_in[7:0];
            t1pfd_pkg::ADDR_TOP:      top_value       <= pwdata_in[7:0];
            t1pfd_pkg::ADDR_DT_PRE:   dead_prescale   <= pwdata_in[1:0];
            t1pfd_pkg::ADDR_DT_VALUE: dead_time_value <= pwdata_in[7:0];
            default:                  ctrl            <= ctrl;
         endcase
      end
   end

   // counter sequence
   always_comb begin
      next_count = count;
      next_down  = count_down;
      ovf_event  = 1'b0;
      if (timer_tick) begin
         case (mode)
            t1pfd_pkg::T1PFD_PFC_PWM: begin
               if (!count_down) begin
                  if (count >= top_eff) begin
                     next_down  = 1'b1;
                     next_count = count - 8'h01;
                  end else begin
                     next_count = count + 8'h01;
                  end
               end else if (count == t1pfd_pkg::CNT_BOTTOM) begin
                  next_down  = 1'b0;
                  next_count = count + 8'h01;
               end else begin
                  next_count = count - 8'h01;
                  ovf_event  = (count == 8'h01);
               end
            end
            default: begin
               next_down = 1'b0;
               if (count == top_eff) begin
                  next_count = t1pfd_pkg::CNT_BOTTOM;
                  ovf_event  = 1'b1;
               end else begin
                  next_count = count + 8'h01;
               end
            end
         endcase
      end
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         count      <= t1pfd_pkg::CNT_BOTTOM;
         count_down <= 1'b0;
      end else begin
         count      <= next_count;
         count_down <= next_down;
      end
   end

   // flags: set wins over any clear in the same cycle
   assign hit_a = timer_tick && (count == compare_a_value);
   assign hit_b = timer_tick && (count == compare_b_value);
   always_comb begin
      set_vec = 8'h00;
      set_vec[t1pfd_pkg::FLAG_CMP_A] = hit_a;
      set_vec[t1pfd_pkg::FLAG_CMP_B] = hit_b;
      set_vec[t1pfd_pkg::FLAG_OVF]   = ovf_event;
      ack_vec = 8'h00;
      ack_vec[t1pfd_pkg::FLAG_CMP_A] = ack_compare_a_in;
      ack_vec[t1pfd_pkg::FLAG_CMP_B] = ack_compare_b_in;
      ack_vec[t1pfd_pkg::FLAG_OVF]   = ack_overflow_in;
      next_flags = ((flags & ~(clr_pend | ack_vec)) | set_vec) & t1pfd_pkg::FLAG_BITS;
   end

   // written ones wait one cycle before they clear
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         clr_pend <= 8'h00;
      end else if (apb_wr && paddr_in == t1pfd_pkg::ADDR_FLAGS) begin
         clr_pend <= pwdata_in[7:0] & t1pfd_pkg::FLAG_BITS;
      end else begin
         clr_pend <= 8'h00;
      end
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         flags <= 8'h00;
      end else begin
         flags <= next_flags;
      end
   end

   // interrupt requests
   assign compare_a_irq_out = global_irq_enable_in && mask[t1pfd_pkg::FLAG_CMP_A] && flags[t1pfd_pkg::FLAG_CMP_A];
   assign compare_b_irq_out = global_irq_enable_in && mask[t1pfd_pkg::FLAG_CMP_B] && flags[t1pfd_pkg::FLAG_CMP_B];
   assign overflow_irq_out  = global_irq_enable_in && mask[t1pfd_pkg::FLAG_OVF] && flags[t1pfd_pkg::FLAG_OVF];
   // summary line ignores the global enable so polling software still sees it
   assign irq_out = |(flags & mask);

   // complementary pair driven from compare A
   assign pwm_raw = count < compare_a_value;

   t1pfd_deadtime i_t1pfd_deadtime (
      .mclk_in                      (mclk_in),
      .rst_in                       (rst_in),
      .timer_tick_in                (timer_tick),
      .dead_prescale_in             (dead_prescale),
      .dead_time_true_output_in     (dead_time_value[t1pfd_pkg::DT_TRUE_LSB +: 4]),
      .dead_time_inverted_output_in (dead_time_value[t1pfd_pkg::DT_INV_LSB +: 4]),
      .pwm_in                       (pwm_raw),
      .pair_true_out                (compare_output_pair_true_out),
      .pair_inv_out                 (compare_output_pair_inv_out)
   );

   // checks
   property p_sync_full_rate;
      @(posedge mclk_in) disable iff (rst_in)
         (clk_sel == 4'h1 && !ctrl[t1pfd_pkg::CTRL_ASYNC_BIT]) |-> timer_tick;
   endproperty
   a_sync_full_rate: assert property (p_sync_full_rate) else $error("undivided clock not every cycle");

   property p_clear_a;
      @(posedge mclk_in) disable iff (rst_in)
         (apb_wr && paddr_in == t1pfd_pkg::ADDR_FLAGS && pwdata_in[t1pfd_pkg::FLAG_CMP_A])
         ##1 !hit_a |=> !flags[t1pfd_pkg::FLAG_CMP_A];
   endproperty
   a_clear_a: assert property (p_clear_a) else $error("compare A flag not cleared");

   property p_irq_a;
      @(posedge mclk_in) disable iff (rst_in)
         (global_irq_enable_in && mask[t1pfd_pkg::FLAG_CMP_A] && flags[t1pfd_pkg::FLAG_CMP_A]) |-> irq_out;
   endproperty
   a_irq_a: assert property (p_irq_a) else $error("compare A request missing");

   property p_set_b;
      @(posedge mclk_in) disable iff (rst_in) hit_b |=> flags[t1pfd_pkg::FLAG_CMP_B];
   endproperty
   a_set_b: assert property (p_set_b) else $error("compare B flag not set");

   property p_ack_b;
      @(posedge mclk_in) disable iff (rst_in)
         (ack_compare_b_in && !hit_b) |=> !flags[t1pfd_pkg::FLAG_CMP_B];
   endproperty
   a_ack_b: assert property (p_ack_b) else $error("compare B flag survived vector");

   property p_irq_b_gated;
      @(posedge mclk_in) disable iff (rst_in) !global_irq_enable_in |-> !compare_b_irq_out;
   endproperty
   a_irq_b_gated: assert property (p_irq_b_gated) else $error("compare B request without enable");

   property p_ovf_wrap;
      @(posedge mclk_in) disable iff (rst_in)
         (timer_tick && mode != t1pfd_pkg::T1PFD_PFC_PWM && count == top_eff)
         |=> (count == t1pfd_pkg::CNT_BOTTOM && flags[t1pfd_pkg::FLAG_OVF]);
   endproperty
   a_ovf_wrap: assert property (p_ovf_wrap) else $error("overflow at top missing");

   property p_ovf_bottom;
      @(posedge mclk_in) disable iff (rst_in)
         (timer_tick && mode == t1pfd_pkg::T1PFD_PFC_PWM && count_down && count == 8'h01)
         |=> (count == t1pfd_pkg::CNT_BOTTOM && flags[t1pfd_pkg::FLAG_OVF]);
   endproperty
   a_ovf_bottom: assert property (p_ovf_bottom) else $error("overflow at bottom missing");

   property p_clear_ovf_late;
      @(posedge mclk_in) disable iff (rst_in)
         (apb_wr && paddr_in == t1pfd_pkg::ADDR_FLAGS && pwdata_in[t1pfd_pkg::FLAG_OVF]
          && flags[t1pfd_pkg::FLAG_OVF] && !ack_overflow_in && !clr_pend[t1pfd_pkg::FLAG_OVF])
         |=> flags[t1pfd_pkg::FLAG_OVF];
   endproperty
   a_clear_ovf_late: assert property (p_clear_ovf_late) else $error("overflow cleared too early");

   property p_irq_ovf;
      @(posedge mclk_in) disable iff (rst_in)
         overflow_irq_out |-> (flags[t1pfd_pkg::FLAG_OVF] && mask[t1pfd_pkg::FLAG_OVF]);
   endproperty
   a_irq_ovf: assert property (p_irq_ovf) else $error("overflow request without cause");

   property p_dt_write;
      @(posedge mclk_in) disable iff (rst_in)
         (apb_wr && paddr_in == t1pfd_pkg::ADDR_DT_VALUE) |=> dead_time_value == $past(pwdata_in[7:0]);
   endproperty
   a_dt_write: assert property (p_dt_write) else $error("dead-time register not written");

   property p_write_zero;
      @(posedge mclk_in) disable iff (rst_in)
         (apb_wr && paddr_in == t1pfd_pkg::ADDR_FLAGS && !pwdata_in[t1pfd_pkg::FLAG_CMP_B]
          && flags[t1pfd_pkg::FLAG_CMP_B] && !clr_pend[t1pfd_pkg::FLAG_CMP_B] && !ack_compare_b_in)
         ##1 !ack_compare_b_in |=> flags[t1pfd_pkg::FLAG_CMP_B];
   endproperty
   a_write_zero: assert property (p_write_zero) else $error("flag cleared by written zero");

   c_ovf_irq: cover property (@(posedge mclk_in) disable iff (rst_in) overflow_irq_out);
   c_pfc_turn: cover property (@(posedge mclk_in) disable iff (rst_in) $rose(count_down));
   c_set_clear_race: cover property (@(posedge mclk_in) disable iff (rst_in) |(set_vec & clr_pend));
   c_pair_rise: cover property (@(posedge mclk_in) disable iff (rst_in) $rose(compare_output_pair_true_out));
endmodule

// ### sim/test_t1pfd_top.sv
// Purpose: self-checking bench for the timer1 prescale, flags and dead-time block
// Assumes: zero wait-state apb slave, flags and mask share one layout
// Notes:   scored reads go through a queue checked by a monitor process
`timescale 1ns/1ps
module test_t1pfd_top;
   logic        mclk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, sc = 0, gie = 0, fpc = 0;
   logic [2:0]  ack = 0;
   logic [7:0]  pa = 0, c0, e;
   logic [31:0] pd = 0, rd, prdata;
   logic        pready, perr, ia, ib, io, irq, pt, pi;
   logic [32:0] q[$];
   int          mismatches = 0, checked = 0, hl;
   t1pfd_top i_t1pfd_top (.mclk_in(mclk), .rst_in(rst), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
      .paddr_in(pa), .pwdata_in(pd), .prdata_out(prdata), .pready_out(pready), .pslverr_out(perr),
      .global_irq_enable_in(gie), .ack_compare_a_in(ack[2]), .ack_compare_b_in(ack[1]),
      .ack_overflow_in(ack[0]), .compare_a_irq_out(ia), .compare_b_irq_out(ib), .overflow_irq_out(io),
      .irq_out(irq), .fast_periph_clk_in(fpc), .compare_output_pair_true_out(pt),
      .compare_output_pair_inv_out(pi));
   initial forever #2.5 mclk = ~mclk;
   // pin clock at a quarter of mclk, well under the half-rate limit
   always #10 fpc = ~fpc;
   task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   always @(posedge mclk) begin
      if (psel && pen && !pwr && sc && pready === 1'b1) cmp({perr, prdata}, q.pop_front());
   end
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic s,
                      input logic [32:0] x);
      @(posedge mclk);
      psel <= 1; pen <= 0; pwr <= w; pa <= a; pd <= d; sc <= s;
      if (s) q.push_back(x);
      @(posedge mclk);
      pen <= 1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      rd = prdata;
      psel <= 0; pen <= 0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1, a, {24'h00_0000, d}, 0, 0);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] x);
      apb(0, a, 0, 1, {25'h000_0000, x});
   endtask
   // length in cycles of the next whole high pulse of one pair output
   task automatic hi_len(input bit w, output int n);
      n = 0;
      while (w ? pi : pt) @(posedge mclk);
      while (!(w ? pi : pt)) @(posedge mclk);
      while (w ? pi : pt) begin
         n++;
         @(posedge mclk);
      end
   endtask
   task automatic stop_test;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      #100000;
      mismatches++;
      stop_test;
   end
   initial begin
      void'($urandom(32'h1b2f));
      repeat (6) @(posedge mclk);
      rst <= 0;
      rdc(t1pfd_pkg::ADDR_DT_VALUE, 8'h00);
      e = 8'($urandom);
      wr(t1pfd_pkg::ADDR_DT_VALUE, e);
      rdc(t1pfd_pkg::ADDR_DT_VALUE, e);
      apb(0, 8'h20, 0, 1, 33'h1_0000_0000);
      wr(t1pfd_pkg::ADDR_DT_PRE, 8'hFF);
      rdc(t1pfd_pkg::ADDR_DT_PRE, 8'h03);
      $display("register test done");
      // top of 8 keeps both compare values out of reach
      wr(t1pfd_pkg::ADDR_CMP_A, 8'h10);
      wr(t1pfd_pkg::ADDR_CMP_B, 8'h20);
      wr(t1pfd_pkg::ADDR_TOP, 8'h08);
      wr(t1pfd_pkg::ADDR_CTRL, 8'h41);
      repeat (40) @(posedge mclk);
      wr(t1pfd_pkg::ADDR_CTRL, 8'h00);
      rdc(t1pfd_pkg::ADDR_FLAGS, 8'h04);
      wr(t1pfd_pkg::ADDR_FLAGS, 8'h04);
      wr(t1pfd_pkg::ADDR_TOP, 8'hFF);
      $display("dual slope test done");
      // 64-cycle window between captures, whole periods of every divider used
      for (int n = 0; n < 9; n++) begin
         wr(t1pfd_pkg::ADDR_CTRL, (n < 8) ? 8'(n) : 8'h11);
         e = (n == 8) ? 8'd16 : (n == 0) ? 8'd0 : 8'(64 >> (n - 1));
         apb(0, t1pfd_pkg::ADDR_COUNT, 0, 0, 0);
         c0 = rd[7:0];
         repeat (61) @(posedge mclk);
         apb(0, t1pfd_pkg::ADDR_COUNT, 0, 0, 0);
         c0 = rd[7:0] - c0;
         cmp({25'h0, c0}, {25'h0, e});
      end
      wr(t1pfd_pkg::ADDR_CTRL, 8'h00);
      $display("prescaler test done");
      wr(t1pfd_pkg::ADDR_FLAGS, 8'h64);
      rdc(t1pfd_pkg::ADDR_FLAGS, 8'h00);
      wr(t1pfd_pkg::ADDR_CTRL, 8'h01);
      repeat (300) @(posedge mclk);
      wr(t1pfd_pkg::ADDR_CTRL, 8'h00);
      rdc(t1pfd_pkg::ADDR_FLAGS, 8'h64);
      wr(t1pfd_pkg::ADDR_FLAGS, 8'h00);
      rdc(t1pfd_pkg::ADDR_FLAGS, 8'h64);
      wr(t1pfd_pkg::ADDR_MASK, 8'h64);
      gie <= 1;
      @(posedge mclk);
      cmp({29'h0, ia, ib, io, irq}, 33'hF);
      gie <= 0;
      @(posedge mclk);
      cmp({29'h0, ia, ib, io, irq}, 33'h1);
      wr(t1pfd_pkg::ADDR_FLAGS, 8'h20);
      rdc(t1pfd_pkg::ADDR_FLAGS, 8'h44);
      ack <= 3'b001;
      @(posedge mclk);
      ack <= 3'b000;
      rdc(t1pfd_pkg::ADDR_FLAGS, 8'h40);
      ack <= 3'b100;
      @(posedge mclk);
      ack <= 3'b000;
      rdc(t1pfd_pkg::ADDR_FLAGS, 8'h00);
      cmp({32'h0, irq}, 33'h0);
      $display("flag test done");
      wr(t1pfd_pkg::ADDR_DT_PRE, 8'h00);
      wr(t1pfd_pkg::ADDR_TOP, 8'h3F);
      wr(t1pfd_pkg::ADDR_CMP_A, 8'h20);
      // fast pwm, 64-tick period, pwm high for 32 ticks
      wr(t1pfd_pkg::ADDR_CTRL, 8'h21);
      for (int k = 0; k < 2; k++) begin
         e = (k == 0) ? 8'h00 : 8'($urandom);
         wr(t1pfd_pkg::ADDR_DT_VALUE, e);
         // settle past any delay left over from the stopped timer
         repeat (200) @(posedge mclk);
         hi_len(0, hl);
         cmp(33'(hl), 33'(31 - e[7:4]));
         hi_len(1, hl);
         cmp(33'(hl), 33'(31 - e[3:0]));
      end
      $display("dead time test done");
      stop_test;
   end
endmodule
